//--- hw/duc_pkg.sv
// Package for the user calibration engine: map, layouts, constants.
package duc_pkg;

  // Number of converter channels served by the engine.
  localparam int DUC_NCH = 8;
  // Width of one data word on the register port.
  localparam int DUC_DW = 16;

  // Register offsets; channel registers use the low three address bits.
  localparam logic [5:0] DUC_OFF_INPUT = 6'h00;
  localparam logic [5:0] DUC_OFF_ZERO = 6'h08;
  localparam logic [5:0] DUC_OFF_GAIN = 6'h10;
  localparam logic [5:0] DUC_OFF_DATA = 6'h18;
  localparam logic [5:0] DUC_OFF_CONFIG = 6'h20;
  localparam logic [5:0] DUC_OFF_BUSY = 6'h21;

  // Field positions.
  localparam int DUC_CFG_ENABLE_BIT = 0;
  localparam int DUC_BUSY_ACTIVE_BIT = 8;

  // Reset values.
  localparam logic [15:0] DUC_GAIN_RST = 16'h8000;
  localparam logic [15:0] DUC_ZERO_RST = 16'h0000;
  localparam logic [15:0] DUC_INPUT_RST = 16'h0000;
  localparam logic [15:0] DUC_DATA_RST = 16'h0000;

  // Rounding term and unity offset of the gain coefficient.
  localparam logic [16:0] DUC_GAIN_UNITY = 17'h08000;
  localparam logic [32:0] DUC_ROUND = 33'h000008000;

  // Service time of one channel and its count of 25 ns cycles.
  localparam int DUC_CLK_MHZ = 40;
  localparam int DUC_SERVICE_NS = 500;
  localparam int DUC_SERVICE_CYC = (DUC_SERVICE_NS * DUC_CLK_MHZ) / 1000;

  // Register bus request carried as one bundle.
  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } duc_req_s;

  // Engine states, Gray coded along idle, load, work, store.
  typedef enum logic [1:0] {
    DUC_IDLE = 2'b00,
    DUC_LOAD = 2'b01,
    DUC_WORK = 2'b11,
    DUC_STORE = 2'b10
  } duc_state_e;

endpackage : duc_pkg

//--- hw/duc_math.sv
// Correction arithmetic: scale by gain, add signed zero, clamp to 16 bits.
`timescale 1ns/1ps
module duc_math (
  input wire logic [15:0] code_i,
  input wire logic [15:0] gain_i,
  input wire logic [15:0] zero_i,
  output logic [15:0] result_o
);
  import duc_pkg::*;

  // Coefficient is gain plus half scale, so it spans 0.5 to 1.5 of unity.
  logic [16:0] coef;
  // Full product with rounding term.
  logic [32:0] prod;
  // Scaled code with guard bits, signed for the offset add.
  logic signed [19:0] scaled;
  // Sum after the signed zero offset.
  logic signed [19:0] sum;

  // Gain is unsigned and zero is twos complement, whatever the format. [RL20]
  always_comb begin
    coef = {1'b0, gain_i} + DUC_GAIN_UNITY; // [RL3]
    prod = 33'({17'h00000, code_i} * {16'h0000, coef}) + DUC_ROUND; // [RL21]
    scaled = signed'({3'b000, prod[32:16]});
    sum = scaled + 20'(signed'(zero_i)); // [RL4]
    // Clamping keeps a wild trim from wrapping the output code.
    if (sum < 0) begin
      result_o = 16'h0000;
    end else if (sum > 20'sh0FFFF) begin
      result_o = 16'hFFFF;
    end else begin
      result_o = sum[15:0];
    end
  end

endmodule : duc_math

//--- hw/duc_engine.sv
// Eight-channel user calibration engine with register port and busy pin.
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - Each channel owns zero and gain registers.
// RL2 - Enabled: channel writes start automatic correction.
// RL3 - Gain coefficient spans half to one and half.
// RL4 - Zero adds signed sixteen-bit offset.
// RL5 - One shared datapath, one channel at once.
// RL6 - Channel write sets its pending flag.
// RL7 - Storing corrected code clears pending flag.
// RL8 - One correction takes about 500 ns.
// RL9 - Channel zero highest, seven lowest priority.
// RL10 - Never start lower while higher pending.
// RL11 - Active: engine flag one, busy pin low.
// RL12 - Idle: flag zero, busy pin released.
// RL13 - Disabled: flag cleared, busy pin released.
// RL14 - Host writes only when safe to.
// RL15 - Host waits for higher corrections first.
// RL16 - Enable bit: zero off, one on, resets zero.
// RL17 - Disabled: input copied straight to data.
// RL18 - Disabled: zero, gain only stored, read back.
// RL19 - Reset: gain 32768, zero and input zero.
// RL20 - Gain unsigned, zero twos complement.
// RL21 - Code equals rounded scaled input plus zero, clamped.
// RL22 - Rewrite of pending channel uses latest values; a rewrite in the last work cycle is left uncorrected.
module duc_engine #(
  parameter int NCH = duc_pkg::DUC_NCH,
  parameter int SERVICE_CYC = duc_pkg::DUC_SERVICE_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [5:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic busy_n_o,
  output logic busy_n_oe_o
);
  import duc_pkg::*;

  // Width of the service-time counter.
  localparam int CW = $clog2(SERVICE_CYC + 1);
  // Last count of the working phase; load and store take one cycle each.
  localparam logic [CW-1:0] WORK_LAST = CW'(SERVICE_CYC - 3);

  // All state of the block in one bundle.
  typedef struct packed {
    logic [NCH-1:0][15:0] input_r;
    logic [NCH-1:0][15:0] zero_r;
    logic [NCH-1:0][15:0] gain_r;
    logic [NCH-1:0][15:0] data_r;
    logic [NCH-1:0] channel_pending_flag;
    logic correction_enable;
    duc_state_e state;
    logic [2:0] chan;
    logic [CW-1:0] cnt;
    logic [15:0] result;
    logic [15:0] rdata;
  } duc_st_s;

  // Current and next state.
  duc_st_s st;
  duc_st_s next_st;
  // Bundled register request.
  duc_req_s req;
  // Decoded channel-register write and its target channel.
  logic chan_wr;
  logic [2:0] wr_chan;
  // Lowest pending channel index and whether any is pending.
  logic [2:0] pick;
  logic any_pending;
  // Output of the shared datapath.
  logic [15:0] math_out;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign wr_chan = req.addr[2:0];
  assign chan_wr = req.wr && (req.addr[5:3] < 3'd3);

  // Priority pick: the loop walks downward so channel zero wins. [RL9]
  always_comb begin
    pick = 3'd0;
    any_pending = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (st.channel_pending_flag[i]) begin
        pick = 3'(i);
        any_pending = 1'b1;
      end
    end
  end

  // One datapath, fed from the latched channel's current registers. [RL5]
  duc_math duc_math_i (
    .code_i(st.input_r[st.chan]),
    .gain_i(st.gain_r[st.chan]),
    .zero_i(st.zero_r[st.chan]),
    .result_o(math_out)
  );

  // Next-state logic: register writes, reads, and the correction sequencer.
  always_comb begin
    next_st = st;
    next_st.rdata = 16'h0000;
    // Register writes; every channel has its own trim registers. [RL1]
    if (req.wr) begin
      case (req.addr[5:3])
        3'd0: begin
          next_st.input_r[wr_chan] = req.wdata;
          // Bypass copies the code straight through. [RL17]
          if (!st.correction_enable) begin
            next_st.data_r[wr_chan] = req.wdata;
          end
        end
        3'd1: next_st.zero_r[wr_chan] = req.wdata; // [RL18]
        3'd2: next_st.gain_r[wr_chan] = req.wdata; // [RL18]
        3'd4: begin
          if (req.addr == DUC_OFF_CONFIG) begin
            next_st.correction_enable = req.wdata[DUC_CFG_ENABLE_BIT]; // [RL16]
          end
        end
        default: begin
        end
      endcase
    end
    // Reads answer next cycle; unmapped addresses read zero.
    if (req.rd) begin
      case (req.addr[5:3])
        3'd0: next_st.rdata = st.input_r[req.addr[2:0]];
        3'd1: next_st.rdata = st.zero_r[req.addr[2:0]]; // [RL18]
        3'd2: next_st.rdata = st.gain_r[req.addr[2:0]]; // [RL18]
        3'd3: next_st.rdata = st.data_r[req.addr[2:0]];
        3'd4: begin
          if (req.addr == DUC_OFF_CONFIG) begin
            next_st.rdata[DUC_CFG_ENABLE_BIT] = st.correction_enable;
          end else if (req.addr == DUC_OFF_BUSY) begin
            next_st.rdata[NCH-1:0] = st.channel_pending_flag;
            next_st.rdata[DUC_BUSY_ACTIVE_BIT] = (st.state != DUC_IDLE);
          end
        end
        default: next_st.rdata = 16'h0000;
      endcase
    end
    // Sequencer: load, work, store; the three together fill the service time. [RL8]
    case (st.state)
      DUC_IDLE: begin
        // A new pick happens only here, so higher channels go first. [RL10]
        if (any_pending && st.correction_enable) begin
          next_st.chan = pick;
          next_st.cnt = '0;
          next_st.state = DUC_LOAD;
        end
      end
      DUC_LOAD: next_st.state = DUC_WORK;
      DUC_WORK: begin
        // Latest register contents are sampled at the end. [RL22]
        if (st.cnt == WORK_LAST) begin
          next_st.result = math_out;
          next_st.state = DUC_STORE;
        end else begin
          next_st.cnt = st.cnt + CW'(1);
        end
      end
      DUC_STORE: begin
        next_st.data_r[st.chan] = st.result; // [RL2]
        next_st.channel_pending_flag[st.chan] = 1'b0; // [RL7]
        next_st.state = DUC_IDLE;
      end
      default: next_st.state = DUC_IDLE;
    endcase
    // Disabling the engine drops any correction in progress.
    if (!st.correction_enable) begin
      next_st.state = DUC_IDLE;
      next_st.channel_pending_flag = '0;
    end
    // A write sets its flag; applied last so it beats the clear. [RL6]
    if (chan_wr && st.correction_enable) begin
      next_st.channel_pending_flag[wr_chan] = 1'b1; // [RL2]
    end
    // A write during store is already kept by the set above; this block repeats it.
    if (chan_wr && st.state == DUC_STORE && wr_chan == st.chan) begin
      next_st.channel_pending_flag[wr_chan] = st.correction_enable; // [RL22]
    end
  end

  // State register with synchronous reset to documented values.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NCH; i++) begin
        st.input_r[i] <= DUC_INPUT_RST; // [RL19]
        st.zero_r[i] <= DUC_ZERO_RST; // [RL19]
        st.gain_r[i] <= DUC_GAIN_RST; // [RL19]
        st.data_r[i] <= DUC_DATA_RST;
      end
      st.channel_pending_flag <= '0;
      st.correction_enable <= 1'b0; // [RL16]
      st.state <= DUC_IDLE;
      st.chan <= 3'd0;
      st.cnt <= '0;
      st.result <= 16'h0000;
      st.rdata <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  // Open-drain busy: driven low while active, released otherwise. [RL11]
  assign busy_n_o = 1'b0;
  assign busy_n_oe_o = (st.state != DUC_IDLE); // [RL12] [RL13]

  // Helper: the pending flags one cycle back, as they stood when the pick was made.
  logic [NCH-1:0] flags_q;
  always_ff @(posedge clk_i) begin
    flags_q <= st.channel_pending_flag;
  end

  sequence s_start;
    st.state == DUC_IDLE && any_pending && st.correction_enable;
  endsequence

  sequence s_finish;
    st.state == DUC_STORE;
  endsequence

  property p_sequence_time;
    @(posedge clk_i) disable iff (!rstn_i)
      s_start ##1 (st.state == DUC_LOAD && st.correction_enable)
      |-> ##[1:20] s_finish;
  endproperty
  a_sequence_time: assert property (p_sequence_time) // [RL8]
    else $error("Correction did not finish in service time.");

  property p_pick_lowest;
    @(posedge clk_i) disable iff (!rstn_i)
      s_start |=> (st.chan == $past(pick)) && (st.state == DUC_LOAD);
  endproperty
  a_pick_lowest: assert property (p_pick_lowest) // [RL9]
    else $error("Engine did not pick the highest priority channel.");

  property p_no_lower;
    @(posedge clk_i) disable iff (!rstn_i)
      (st.state == DUC_LOAD) |-> ((flags_q & ((8'h01 << st.chan) - 8'h01))
      == '0);
  endproperty
  a_no_lower: assert property (p_no_lower) // [RL10]
    else $error("Lower channel started while higher one pending.");

  property p_set_flag;
    @(posedge clk_i) disable iff (!rstn_i)
      (chan_wr && st.correction_enable) |=>
      st.channel_pending_flag[$past(wr_chan)];
  endproperty
  a_set_flag: assert property (p_set_flag) // [RL6]
    else $error("Pending flag not set by channel write.");

  property p_clear_flag;
    @(posedge clk_i) disable iff (!rstn_i)
      (s_finish and !chan_wr) |=> !st.channel_pending_flag[$past(st.chan)]
      && st.data_r[$past(st.chan)] == $past(st.result);
  endproperty
  a_clear_flag: assert property (p_clear_flag) // [RL7]
    else $error("Store did not clear flag or write data.");

  property p_busy_pin;
    @(posedge clk_i) disable iff (!rstn_i)
      busy_n_oe_o == (st.state != DUC_IDLE) && !busy_n_o;
  endproperty
  a_busy_pin: assert property (p_busy_pin) // [RL11]
    else $error("Busy pin does not follow engine activity.");

  property p_disabled_quiet;
    @(posedge clk_i) disable iff (!rstn_i)
      (!st.correction_enable) [*2] |-> !busy_n_oe_o && st.state == DUC_IDLE;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) // [RL13]
    else $error("Engine active while correction disabled.");

  property p_bypass;
    @(posedge clk_i) disable iff (!rstn_i)
      (req.wr && req.addr[5:3] == 3'd0 && !st.correction_enable) |=>
      st.data_r[$past(wr_chan)] == $past(req.wdata);
  endproperty
  a_bypass: assert property (p_bypass) // [RL17]
    else $error("Bypass write not copied to data register.");

  property p_idle_release;
    @(posedge clk_i) disable iff (!rstn_i)
      (st.state == DUC_STORE && !chan_wr &&
      ($countones(st.channel_pending_flag) == 1)) |=> ##1 busy_n_oe_o == 1'b0
      || st.channel_pending_flag != '0;
  endproperty
  a_idle_release: assert property (p_idle_release) // [RL12]
    else $error("Busy pin not released after last correction.");

  // Helper: cycles since the engine left idle; zero from the second idle cycle on.
  // A counter keeps the timing check short where a repeat would not.
  logic [CW-1:0] busy_cyc;
  always_ff @(posedge clk_i) begin
    if (!rstn_i || st.state == DUC_IDLE) begin
      busy_cyc <= '0;
    end else begin
      busy_cyc <= busy_cyc + CW'(1);
    end
  end

  // Store must fall in the last cycle of one service time after leaving idle.
  property p_store_time;
    @(posedge clk_i) disable iff (!rstn_i)
      s_finish |-> busy_cyc == CW'(SERVICE_CYC - 1);
  endproperty
  a_store_time: assert property (p_store_time) // [RL8]
    else $error("Store cycle does not match the service time.");

  // A read of the busy register must agree with the pin and the flags.
  sequence s_busy_read;
    req.rd && req.addr == DUC_OFF_BUSY;
  endsequence

  property p_active_flag;
    @(posedge clk_i) disable iff (!rstn_i)
      s_busy_read |=> rdata_o[DUC_BUSY_ACTIVE_BIT] == $past(busy_n_oe_o)
      && rdata_o[NCH-1:0] == $past(st.channel_pending_flag);
  endproperty
  a_active_flag: assert property (p_active_flag) // [RL11]
    else $error("Busy register disagrees with the busy pin.");

  // A disabled engine queues nothing, so trim writes are only stored.
  property p_store_only;
    @(posedge clk_i) disable iff (!rstn_i)
      (chan_wr && !st.correction_enable) |=>
      st.channel_pending_flag == '0 && st.state == DUC_IDLE;
  endproperty
  a_store_only: assert property (p_store_only) // [RL18]
    else $error("Disabled write started a correction.");

  // One disabled cycle is enough to bring the sequencer home.
  property p_disabled_idle;
    @(posedge clk_i) disable iff (!rstn_i)
      !st.correction_enable |=> st.state == DUC_IDLE;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) // [RL13]
    else $error("Sequencer left idle while correction disabled.");

  // Reset is the antecedent here, so this one has no disable clause.
  sequence s_in_reset;
    !rstn_i;
  endsequence

  property p_reset_values;
    @(posedge clk_i)
      s_in_reset |=> st.gain_r == {NCH{DUC_GAIN_RST}}
      && st.zero_r == {NCH{DUC_ZERO_RST}}
      && st.input_r == {NCH{DUC_INPUT_RST}}
      && rdata_o == 16'h0000 && !busy_n_oe_o;
  endproperty
  a_reset_values: assert property (p_reset_values) // [RL19]
    else $error("Registers not at reset values after reset.");

endmodule : duc_engine

//--- test/duc_host.sv
// Host model: register bus master and pulled-up busy line.
`timescale 1ns/1ps
module duc_host (
  input wire logic clk_i,
  output duc_pkg::duc_req_s req_o,
  input wire logic [15:0] rdata_i,
  input wire logic busy_n_i,
  input wire logic busy_n_oe_i,
  output logic busy_line_o
);
  import duc_pkg::*;

  // The line has a pull-up, so a released pin reads high.
  assign busy_line_o = busy_n_oe_i ? busy_n_i : 1'b1;

  initial begin
    req_o = '0;
  end

  // One-cycle write strobe beside address and data.
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req_o.wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe edge.
  task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk_i);
    req_o <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req_o.rd <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd_reg

  // Rewrites wait until every pending flag has cleared.
  task automatic wait_idle(output logic ok);
    logic [15:0] b;
    ok = 1'b0;
    for (int i = 0; i < 300 && !ok; i++) begin
      rd_reg(DUC_OFF_BUSY, b);
      ok = (b === 16'h0000);
    end
  endtask : wait_idle
endmodule : duc_host

//--- test/duc_engine_tb.sv
// Self-checking bench for the calibration engine.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module duc_engine_tb;
  import duc_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  duc_req_s req; // Bus request from the host.
  logic [15:0] rdata; // Read data towards the host.
  logic busy_n, busy_oe, busy_line; // Busy pin pieces.
  int n_mismatch = 0;
  int cmp_count = 0;

  // Half period of 12.5 ns gives 40 MHz.
  always #12.5 clk_i = ~clk_i;

  duc_engine duc_engine_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .addr_i(req.addr), .wdata_i(req.wdata), .wr_i(req.wr), .rd_i(req.rd),
    .rdata_o(rdata), .busy_n_o(busy_n), .busy_n_oe_o(busy_oe));
  duc_host duc_host_i (.clk_i(clk_i), .req_o(req), .rdata_i(rdata),
    .busy_n_i(busy_n), .busy_n_oe_i(busy_oe), .busy_line_o(busy_line));

  // Reference result, kept apart from the design's arithmetic.
  function automatic logic [15:0] corr(logic [15:0] x, g, z);
    longint p;
    p = (longint'(x) * (longint'(g) + 32768) + 32768) >>> 16;
    p = p + longint'($signed(z));
    return (p < 0) ? 16'h0000 : (p > 65535) ? 16'hFFFF : 16'(p);
  endfunction : corr

  // Prints the counts and the verdict, then stops.
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // Waits for an idle engine and counts a hang as a mismatch.
  task automatic idle;
    logic ok;
    duc_host_i.wait_idle(ok);
    `CHK(ok, 1'b1)
  endtask : idle

  // Reset values of every channel's gain, zero and input registers and of config and busy.
  task automatic t_reset;
    logic [15:0] d;
    for (int c = 0; c < 8; c++) begin
      duc_host_i.rd_reg(DUC_OFF_GAIN + 6'(c), d);
      `CHK(d, 16'h8000)
      duc_host_i.rd_reg(DUC_OFF_ZERO + 6'(c), d);
      `CHK(d, 16'h0000)
      duc_host_i.rd_reg(DUC_OFF_INPUT + 6'(c), d);
      `CHK(d, 16'h0000)
    end
    duc_host_i.rd_reg(DUC_OFF_CONFIG, d);
    `CHK(d, 16'h0000)
    duc_host_i.rd_reg(DUC_OFF_BUSY, d);
    `CHK(d, 16'h0000)
    $display("done reset values");
  endtask : t_reset

  // Disabled engine: input copied, gain only stored.
  task automatic t_bypass;
    logic [15:0] d;
    duc_host_i.wr_reg(DUC_OFF_GAIN + 6'd3, 16'h1234);
    duc_host_i.wr_reg(DUC_OFF_INPUT + 6'd3, 16'hABCD);
    // Look at the pin mid-cycle, once the state after the write has settled.
    @(negedge clk_i);
    `CHK(busy_line, 1'b1)
    duc_host_i.rd_reg(DUC_OFF_DATA + 6'd3, d);
    `CHK(d, 16'hABCD)
    duc_host_i.rd_reg(DUC_OFF_GAIN + 6'd3, d);
    `CHK(d, 16'h1234)
    duc_host_i.rd_reg(DUC_OFF_BUSY, d);
    `CHK(d, 16'h0000)
    $display("done bypass");
  endtask : t_bypass

  // Gain extremes, a negative zero, both clamps, and each write kind starting work.
  task automatic t_math;
    logic [15:0] d;
    duc_host_i.wr_reg(DUC_OFF_CONFIG, 16'h0001);
    duc_host_i.wr_reg(DUC_OFF_GAIN + 6'd1, 16'hFFFF);
    idle();
    duc_host_i.wr_reg(DUC_OFF_INPUT + 6'd1, 16'hF000);
    idle();
    duc_host_i.rd_reg(DUC_OFF_DATA + 6'd1, d);
    `CHK(d, 16'hFFFF)
    duc_host_i.wr_reg(DUC_OFF_GAIN + 6'd1, 16'h0000);
    idle();
    duc_host_i.rd_reg(DUC_OFF_DATA + 6'd1, d);
    `CHK(d, corr(16'hF000, 16'h0000, 16'h0000))
    duc_host_i.wr_reg(DUC_OFF_INPUT + 6'd2, 16'h0008);
    idle();
    duc_host_i.wr_reg(DUC_OFF_ZERO + 6'd2, 16'hFFF0);
    idle();
    duc_host_i.rd_reg(DUC_OFF_DATA + 6'd2, d);
    `CHK(d, 16'h0000)
    $display("done arithmetic");
  endtask : t_math

  // Busy pin low for one service time; flags and active bit meanwhile.
  task automatic t_busy;
    int n;
    logic [15:0] d;
    n = 0;
    duc_host_i.wr_reg(DUC_OFF_INPUT + 6'd4, 16'h4000);
    duc_host_i.wr_reg(DUC_OFF_INPUT + 6'd4, 16'h2000); // Rewrite while pending.
    duc_host_i.rd_reg(DUC_OFF_BUSY, d);
    `CHK(d, 16'h0110)
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      if (busy_line === 1'b0) n++;
    end
    `CHK(n + 4, DUC_SERVICE_CYC)
    `CHK(busy_line, 1'b1)
    duc_host_i.rd_reg(DUC_OFF_DATA + 6'd4, d);
    `CHK(d, corr(16'h2000, 16'h8000, 16'h0000))
    $display("done busy pin");
  endtask : t_busy

  // Channel three finishes while channel five still waits.
  task automatic t_prio;
    logic [15:0] d;
    duc_host_i.wr_reg(DUC_OFF_INPUT + 6'd0, 16'h0100);
    duc_host_i.wr_reg(DUC_OFF_INPUT + 6'd5, 16'h0500);
    duc_host_i.wr_reg(DUC_OFF_INPUT + 6'd3, 16'h0300);
    d = 16'h0008;
    for (int i = 0; i < 100 && d[3]; i++) begin
      duc_host_i.rd_reg(DUC_OFF_BUSY, d);
    end
    `CHK(d[5], 1'b1)
    idle();
    duc_host_i.rd_reg(DUC_OFF_DATA + 6'd5, d);
    `CHK(d, corr(16'h0500, 16'h8000, 16'h0000))
    $display("done priority");
  endtask : t_prio

  // The tests take a few hundred cycles; this limit leaves ample margin.
  initial begin
    #(25 * 20000);
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_bypass();
    t_math();
    t_busy();
    t_prio();
    final_report();
  end
endmodule : duc_engine_tb
